// *** verilog/nco_pkg.sv ***
// shared constants, register map and carrier types of the phase-accumulator synthesiser
package nco_pkg;
   // ------------------------------------------------------------------
   // datapath widths
   // ------------------------------------------------------------------
   localparam int ACC_W     = 48;  // phase accumulator bits
   localparam int INC_DYN_W = 32;  // dynamic increment input bits
   localparam int QNT_W     = 10;  // quantised phase bits (table address)
   localparam int QTR_N     = 256; // table entries per quarter wave
   localparam int OUT_W     = 16;  // two's-complement sample bits
   localparam int CHAN_MAX  = 16;  // time-multiplexed channels
   localparam int CHAN_W    = 4;   // channel index bits
   localparam int LFSR_W    = 16;  // dither generator bits
   localparam int DITH_LSB  = ACC_W - QNT_W - LFSR_W; // dither lands below the slice

   // ------------------------------------------------------------------
   // amplitude scales and fixed sources
   // ------------------------------------------------------------------
   localparam int AMP_FULL = 32767; // full dynamic range
   localparam int AMP_UNIT = 16384; // unit circle, one below top bit
   localparam logic [ACC_W-1:0]  FIXED_INC = 48'h0000_0100_0000; // constant increment
   localparam logic [ACC_W-1:0]  FIXED_PHS = 48'h0000_0000_0000; // constant offset
   localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hace1;            // dither seed
   localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hb400;            // galois taps

   // ------------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] ADR_CTRL   = 8'h00; // control word
   localparam logic [7:0] ADR_CHSEL  = 8'h04; // channel picked for inc/offset access
   localparam logic [7:0] ADR_INC_LO = 8'h08; // increment bits 31:0
   localparam logic [7:0] ADR_INC_HI = 8'h0c; // increment bits 47:32
   localparam logic [7:0] ADR_PHS_LO = 8'h10; // offset bits 31:0
   localparam logic [7:0] ADR_PHS_HI = 8'h14; // offset bits 47:32
   localparam logic [7:0] ADR_STATUS = 8'h18; // channel being served
   localparam logic [7:0] ADR_SAMPLE = 8'h1c; // last cosine and sine sample

   // ------------------------------------------------------------------
   // modes and control word
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {MODE_SINE, MODE_COS, MODE_QUAD} out_mode_e;
   typedef enum logic [1:0] {SRC_FIXED, SRC_PROG, SRC_DYN} src_e;

   typedef struct packed {
      logic [3:0] nch_m1;   // [15:12] channels in use minus one
      logic       rsv;      // [11] reads zero
      logic       phs_en;   // [10] offset enable
      src_e       phs_src;  // [9:8] offset source
      src_e       inc_src;  // [7:6] increment source
      logic       dither;   // [5] phase dither enable
      logic       amp_unit; // [4] unit circle amplitude
      logic       inv_cos;  // [3] negate cosine
      logic       inv_sin;  // [2] negate sine
      out_mode_e  mode;     // [1:0] sine, cosine or quadrature
   } ctrl_s;

   localparam ctrl_s CTRL_RST = '{nch_m1: 4'h0, rsv: 1'b0, phs_en: 1'b0, phs_src: SRC_PROG,
                                  inc_src: SRC_PROG, dither: 1'b0, amp_unit: 1'b0,
                                  inv_cos: 1'b0, inv_sin: 1'b0, mode: MODE_QUAD};

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic        psel;    // slave selected
      logic        penable; // access phase
      logic        pwrite;  // write when high
      logic [7:0]  paddr;   // byte address
      logic [31:0] pwdata;  // write data
   } apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;  // read data
      logic        pready;  // transfer done
      logic        pslverr; // unmapped address
   } apb_rsp_s;

   typedef struct packed {
      logic              valid; // sample present
      logic [CHAN_W-1:0] chan;  // channel of this sample
      logic [OUT_W-1:0]  sin;   // sine sample
      logic [OUT_W-1:0]  cos;   // cosine sample
   } sample_s;
endpackage

// *** verilog/sin_cos_table.sv ***
// quarter-wave sine/cosine lookup table with two amplitude scales
`timescale 1ns/1ps
module sin_cos_table (
   input  wire logic [nco_pkg::QNT_W-1:0] i_addr,     // quantised phase
   input  wire logic                      i_amp_unit, // unit circle scale
   output logic      [nco_pkg::OUT_W-1:0] o_sin,      // sine sample
   output logic      [nco_pkg::OUT_W-1:0] o_cos       // cosine sample
);
   import nco_pkg::*;

   // ------------------------------------------------------------------
   // table contents
   // ------------------------------------------------------------------
   // sine of k quarter steps by series, evaluated at elaboration only
   function automatic logic [OUT_W-1:0] quarter_val(input int k, input int amp);
      real x;
      real x2;
      real t;
      real s;
      x  = 3.14159265358979 * k / (2.0 * QTR_N);
      x2 = x * x;
      t  = x;
      s  = x;
      for (int n = 1; n < 9; n++) begin
         t = -t * x2 / ((2 * n) * (2 * n + 1));
         s = s + t;
      end
      return OUT_W'($rtoi(s * amp + 0.5));
   endfunction

   logic [OUT_W-1:0] rom_full [0:QTR_N]; // entries 0..256, endpoint kept for mirror
   logic [OUT_W-1:0] rom_unit [0:QTR_N]; // same wave at unit circle scale

   // uniform samples of one quarter, 2^QNT_W points per full cycle
   for (genvar k = 0; k <= QTR_N; k++) begin : g_rom
      assign rom_full[k] = quarter_val(k, AMP_FULL);
      assign rom_unit[k] = quarter_val(k, AMP_UNIT);
   end

   // ------------------------------------------------------------------
   // quadrant mapping, one pass for sine and one for cosine
   // ------------------------------------------------------------------
   logic [OUT_W-1:0] wave [0:1]; // 0 sine, 1 cosine

   for (genvar g = 0; g < 2; g++) begin : g_wave
      logic [QNT_W-1:0] a;   // cosine reads a quarter turn ahead
      logic [8:0]       idx; // index into the quarter
      logic [OUT_W-1:0] mag; // magnitude before sign
      assign a = i_addr + QNT_W'(g * QTR_N);
      // top two bits pick the quadrant, odd quadrants run backwards
      assign idx = a[QNT_W-2] ? 9'(9'h100 - {1'b0, a[QNT_W-3:0]})
                              : {1'b0, a[QNT_W-3:0]};
      assign mag = i_amp_unit ? rom_unit[idx] : rom_full[idx];
      assign wave[g] = a[QNT_W-1] ? OUT_W'(-mag) : mag;
   end

   assign o_sin = wave[0];
   assign o_cos = wave[1];
endmodule // sin_cos_table

// *** verilog/nco_core.sv ***
// multi-channel phase accumulator synthesiser with apb register file
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
module nco_core (
   input  wire logic                          I_CLK,     // 100 MHz system clock
   input  wire logic                          I_RSTN,    // synchronous reset, active low
   input  wire logic                          I_CE,      // clock enable, freezes all state
   input  wire nco_pkg::apb_req_s             I_APB,     // apb request
   output nco_pkg::apb_rsp_s                  O_APB,     // apb answer
   input  wire logic [nco_pkg::INC_DYN_W-1:0] I_INC_DYN, // per-sample increment
   input  wire logic [nco_pkg::ACC_W-1:0]     I_PHS_DYN, // per-sample offset
   output nco_pkg::sample_s                   O_SAMPLE   // sample stream
);
   import nco_pkg::*;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [CHAN_MAX-1:0][ACC_W-1:0] acc;   // phase_state_register per channel
      logic [CHAN_MAX-1:0][ACC_W-1:0] inc;   // programmed increments
      logic [CHAN_MAX-1:0][ACC_W-1:0] phs;   // programmed offsets
      ctrl_s                          ctrl;  // control word
      logic [CHAN_W-1:0]              chsel; // channel for inc/offset access
      logic [CHAN_W-1:0]              ch;    // channel served this cycle
      logic [LFSR_W-1:0]              lfsr;  // dither sequence
      logic                           v1;    // quantised phase valid
      logic [CHAN_W-1:0]              ch1;   // its channel
      logic [QNT_W-1:0]               qnt;   // quantised phase
      logic [31:0]                    rdata; // read data caught at setup
      logic                           err;   // unmapped flag caught at setup
      sample_s                        smp;   // output sample register
   } state_s;

   state_s q; // registered state
   state_s d; // next state

   logic [ACC_W-1:0] acc_cur; // accumulator of served channel
   logic [ACC_W-1:0] inc_w;   // increment in use
   logic [ACC_W-1:0] phs_w;   // offset in use, zero when disabled
   logic [ACC_W-1:0] dith_w;  // dither term
   logic [ACC_W-1:0] phase_w; // phase presented to the slicer
   logic [OUT_W-1:0] tab_sin; // table sine
   logic [OUT_W-1:0] tab_cos; // table cosine
   logic             setup;   // apb setup phase
   logic             access;  // apb access phase that completes
   logic             hit;     // address is mapped
   logic [31:0]      rd_mux;  // read data selection

   // ------------------------------------------------------------------
   // source selection and phase arithmetic
   // ------------------------------------------------------------------
   // accumulator, increment and offset of the channel served now
   always_comb begin
      acc_cur = q.acc[q.ch];
      unique case (q.ctrl.inc_src)
         SRC_FIXED: inc_w = FIXED_INC;
         SRC_DYN:   inc_w = {{(ACC_W-INC_DYN_W){1'b0}}, I_INC_DYN}; // zero fill
         default:   inc_w = q.inc[q.ch];
      endcase
      unique case (q.ctrl.phs_src)
         SRC_FIXED: phs_w = FIXED_PHS;
         SRC_DYN:   phs_w = I_PHS_DYN;
         default:   phs_w = q.phs[q.ch];
      endcase
      if (!q.ctrl.phs_en) begin
         phs_w = '0;
      end
      // dither sits just under the slice so it only breaks up truncation error
      dith_w = q.ctrl.dither ? (ACC_W'(q.lfsr) << DITH_LSB) : '0;
      // modulo 2^48 sum, same bits whether read as signed or unsigned
      phase_w = ACC_W'(acc_cur + phs_w + dith_w);
   end

   // ------------------------------------------------------------------
   // table
   // ------------------------------------------------------------------
   sin_cos_table u_table (
      .i_addr     (q.qnt),
      .i_amp_unit (q.ctrl.amp_unit),
      .o_sin      (tab_sin),
      .o_cos      (tab_cos)
   );

   // ------------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------------
   // register read mux, reserved bits read zero
   always_comb begin
      hit    = 1'b1;
      rd_mux = '0;
      unique case (I_APB.paddr)
         ADR_CTRL:   rd_mux = {16'h0000, q.ctrl};
         ADR_CHSEL:  rd_mux = {28'h0000000, q.chsel};
         ADR_INC_LO: rd_mux = q.inc[q.chsel][31:0];
         ADR_INC_HI: rd_mux = {16'h0000, q.inc[q.chsel][ACC_W-1:32]};
         ADR_PHS_LO: rd_mux = q.phs[q.chsel][31:0];
         ADR_PHS_HI: rd_mux = {16'h0000, q.phs[q.chsel][ACC_W-1:32]};
         ADR_STATUS: rd_mux = {28'h0000000, q.ch};
         ADR_SAMPLE: rd_mux = {q.smp.cos, q.smp.sin};
         default:    hit = 1'b0; // unmapped
      endcase
   end

   assign setup  = I_APB.psel && !I_APB.penable;
   assign access = I_APB.psel && I_APB.penable && I_CE;

   // zero wait states unless the clock enable holds the block
   assign O_APB.pready  = access;
   assign O_APB.prdata  = q.rdata;
   assign O_APB.pslverr = q.err && access;
   assign O_SAMPLE      = q.smp;

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      d = q;
      if (I_CE) begin
         // integrate the served channel, carry out of bit 47 dropped
         d.acc[q.ch] = ACC_W'(acc_cur + inc_w);
         // round robin, so each channel steps once per nch_m1+1 clocks
         if (q.ch >= q.ctrl.nch_m1) begin
            d.ch = '0;
         end else begin
            d.ch = CHAN_W'(q.ch + 1'b1);
         end
         // galois lfsr steps every cycle
         d.lfsr = (q.lfsr >> 1) ^ (q.lfsr[0] ? LFSR_TAPS : '0);
         // slicer keeps the top bits as table address
         d.v1  = 1'b1;
         d.ch1 = q.ch;
         d.qnt = phase_w[ACC_W-1 -: QNT_W];
         // output stage: optional negation then mode select
         d.smp.valid = q.v1;
         d.smp.chan  = q.ch1;
         d.smp.sin   = q.ctrl.inv_sin ? OUT_W'(-tab_sin) : tab_sin;
         d.smp.cos   = q.ctrl.inv_cos ? OUT_W'(-tab_cos) : tab_cos;
         unique case (q.ctrl.mode)
            MODE_SINE: d.smp.cos = '0;
            MODE_COS:  d.smp.sin = '0;
            default:   ;          // quadrature keeps both
         endcase
         // capture read data and error in setup, shown in access
         if (setup) begin
            d.rdata = rd_mux;
            d.err   = !hit;
         end
         // writes land at the completing access edge
         if (access && I_APB.pwrite) begin
            unique case (I_APB.paddr)
               ADR_CTRL: begin
                  d.ctrl     = ctrl_s'(I_APB.pwdata[15:0]);
                  d.ctrl.rsv = 1'b0;
               end
               ADR_CHSEL:  d.chsel = I_APB.pwdata[CHAN_W-1:0];
               ADR_INC_LO: d.inc[q.chsel][31:0] = I_APB.pwdata;
               ADR_INC_HI: d.inc[q.chsel][ACC_W-1:32] = I_APB.pwdata[15:0];
               ADR_PHS_LO: d.phs[q.chsel][31:0] = I_APB.pwdata;
               ADR_PHS_HI: d.phs[q.chsel][ACC_W-1:32] = I_APB.pwdata[15:0];
               default:    ; // read-only or unmapped: no effect
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   // whole state in one register, synchronous reset
   always_ff @(posedge I_CLK) begin
      if (!I_RSTN) begin
         q       <= '0;
         q.ctrl  <= CTRL_RST;
         q.lfsr  <= LFSR_SEED;
      end else begin
         q <= d;
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   AST_FREEZE: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      !I_CE |=> $stable(q))
      else $error("state moved while clock enable low");

   AST_ACC_STEP: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (I_CE && q.ch == 4'h0 && q.ctrl.inc_src == SRC_FIXED)
      |=> q.acc[0] == ACC_W'($past(q.acc[0]) + FIXED_INC))
      else $error("channel 0 accumulator did not advance by increment");

   AST_OTHER_HELD: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (I_CE && q.ch == 4'h0) |=> $stable(q.acc[1]))
      else $error("idle channel accumulator changed");

   AST_ROUND_ROBIN: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (I_CE && q.ctrl.nch_m1 == 4'h3 && q.ch == 4'h0 && !(access && I_APB.pwrite))
      ##1 (I_CE && !(access && I_APB.pwrite)) [*3] |=> q.ch == 4'h0)
      else $error("four channel rotation broken");

   AST_SLICE: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (I_CE && !q.ctrl.dither && !q.ctrl.phs_en)
      |=> q.qnt == $past(acc_cur[ACC_W-1 -: QNT_W]))
      else $error("table address not top accumulator bits");

   AST_ZERO_EXT: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      q.ctrl.inc_src == SRC_DYN |-> inc_w[ACC_W-1:INC_DYN_W] == '0)
      else $error("dynamic increment not zero filled");

   AST_CHAN_TAG: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      I_CE ##1 I_CE |=> O_SAMPLE.valid && O_SAMPLE.chan == $past(q.ch, 2))
      else $error("sample channel tag misaligned");

   AST_SINE_ONLY: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (I_CE && q.ctrl.mode == MODE_SINE) |=> O_SAMPLE.cos == '0)
      else $error("cosine present in sine-only mode");

   AST_PEAK: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (I_CE && q.qnt == 10'h100 && !q.ctrl.amp_unit && !q.ctrl.inv_sin
       && q.ctrl.mode == MODE_QUAD) |=> O_SAMPLE.sin == OUT_W'(AMP_FULL))
      else $error("full range peak wrong");

   AST_INVERT: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (I_CE && q.ctrl.inv_cos && q.ctrl.mode != MODE_SINE)
      |=> O_SAMPLE.cos == OUT_W'(-$past(tab_cos)))
      else $error("cosine not negated");

   AST_UNMAPPED: assert property (@(posedge I_CLK) disable iff (!I_RSTN)
      (I_CE && setup && I_APB.paddr == 8'h20) ##1 access |-> O_APB.pslverr)
      else $error("unmapped address without error");
endmodule // nco_core

// *** tb/nco_sample_sink.sv ***
// downstream consumer model that latches every valid sample of the stream
`timescale 1ns/1ps
module nco_sample_sink (
   input  wire logic             i_clk,    // system clock
   input  wire logic             i_rstn,   // synchronous reset, active low
   input  wire nco_pkg::sample_s i_sample, // sample stream from the synthesiser
   output nco_pkg::sample_s      o_last,   // last valid sample taken
   output logic [15:0]           o_count   // valid samples taken
);
   import nco_pkg::*;
   // ----------------------------------------------------------------
   // capture
   // ----------------------------------------------------------------
   // takes each sample in the cycle it stands, like a dac latch would
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_last  <= '0;
         o_count <= '0;
      end else if (i_sample.valid) begin // two's-complement word with channel
         o_last  <= i_sample;
         o_count <= o_count + 16'h1;
      end
   end
endmodule // nco_sample_sink

// *** tb/phase_accumulator_sine_synth_bench.sv ***
// self-checking bench for the multi-channel phase accumulator synthesiser
`timescale 1ns/1ps
module phase_accumulator_sine_synth_bench;
   import nco_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic                 clk = 1'b0;     // 100 MHz clock
   logic                 rstn = 1'b0;    // reset, active low
   logic                 ce = 1'b1;      // clock enable
   apb_req_s             req = '0;       // apb request
   apb_rsp_s             rsp;            // apb answer
   logic [INC_DYN_W-1:0] inc_dyn = '0;   // dynamic increment
   logic [ACC_W-1:0]     phs_dyn = '0;   // dynamic offset
   sample_s              smp;            // sample stream
   sample_s              last;           // sample held by the consumer
   logic [15:0]          cnt;            // samples consumed
   int                   mismatches = 0; // failed comparisons
   int                   n_tests = 0;    // comparisons made
   int                   cyc = 0;        // cycles since start
   int                   k0, c0;         // quarter index base and its cycle
   logic [31:0]          rd;             // read data
   logic                 err;            // slave error
   nco_core DUT (.I_CLK(clk), .I_RSTN(rstn), .I_CE(ce), .I_APB(req), .O_APB(rsp),
                 .I_INC_DYN(inc_dyn), .I_PHS_DYN(phs_dyn), .O_SAMPLE(smp));
   nco_sample_sink sink (.i_clk(clk), .i_rstn(rstn), .i_sample(smp), .o_last(last),
                         .o_count(cnt));
   always #5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic test_done();
      if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one apb transfer, held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge clk);
      req.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 50);
      if (rsp.pready !== 1'b1) chk("pready", 32'h0, 32'h1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
   endtask
   task automatic wctrl(input ctrl_s c);
      apb(1'b1, ADR_CTRL, {16'h0, c});
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic do_reset();
      @(posedge clk);
      rstn <= 1'b0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
   endtask
   // sine at quarter point k
   function automatic logic [15:0] sv(input int k, input int a);
      case (k & 3)
         1: return 16'(a);
         3: return 16'(-a);
         default: return 16'h0000;
      endcase
   endfunction
   // expected {cos, sin} word at quarter point k under a control word
   function automatic logic [31:0] exp_smp(input int k, input ctrl_s c, input int a);
      logic [15:0] s, co;
      s = sv(k, a);
      co = sv(k + 1, a);
      if (c.inv_sin) s = -s;
      if (c.inv_cos) co = -co;
      if (c.mode == MODE_SINE) co = 16'h0000;
      if (c.mode == MODE_COS) s = 16'h0000;
      return {co, s};
   endfunction
   function automatic int findk(input logic [31:0] w, input int a);
      for (int k = 0; k < 4; k++) if (w === exp_smp(k, CTRL_RST, a)) return k;
      return -1;
   endfunction
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      apb(1'b0, ADR_CTRL, 32'h0);
      chk("ctrl reset", rd, {16'h0, CTRL_RST});
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped err", {31'h0, err}, 32'h1);
      chk("unmapped data", rd, 32'h0);
   endtask
   // quarter turn per clock, every mode, inversion and amplitude
   task automatic t_rot();
      ctrl_s c;
      apb(1'b1, ADR_INC_HI, 32'h0000_4000); // integer increment
      step(4);
      k0 = findk({last.cos, last.sin}, AMP_FULL);
      c0 = cyc;
      chk("base point", 32'(k0 >= 0), 32'h1);
      for (int m = 0; m < 3; m++) begin
         for (int v = 0; v < 8; v++) begin
            c = CTRL_RST;
            c.mode = out_mode_e'(m);
            c.inv_sin = v[0];
            c.inv_cos = v[1];
            c.amp_unit = v[2];
            // dither only fills bits under the slice, quarter points stay exact
            c.dither = v[0];
            wctrl(c);
            step(4);
            for (int i = 0; i < 4; i++) begin
               step(1);
               chk("rotation", {last.cos, last.sin}, exp_smp(k0 + cyc - c0, c, v[2] ? AMP_UNIT : AMP_FULL));
            end
         end
      end
   endtask
   // offsets from each source, and a narrow dynamic increment
   task automatic t_offs();
      ctrl_s c;
      do_reset();
      c = CTRL_RST;
      c.phs_en = 1'b1;
      wctrl(c);
      apb(1'b1, ADR_PHS_HI, 32'h0000_4000);
      step(4);
      chk("prog offset", {last.cos, last.sin}, exp_smp(1, c, AMP_FULL));
      c.phs_src = SRC_FIXED;
      wctrl(c);
      step(4);
      chk("fixed offset", {last.cos, last.sin}, exp_smp(0, c, AMP_FULL));
      c.phs_src = SRC_DYN;
      @(posedge clk);
      phs_dyn <= 48'h8000_0000_0000;
      wctrl(c);
      step(4);
      chk("dyn offset", {last.cos, last.sin}, exp_smp(2, c, AMP_FULL));
      c.phs_en = 1'b0;
      c.inc_src = SRC_DYN;
      @(posedge clk);
      inc_dyn <= 32'h8000_0000;
      wctrl(c);
      step(40);
      chk("zero extend", {last.cos, last.sin}, exp_smp(0, c, AMP_FULL));
   endtask
   // four channels with one moving, then all sixteen
   task automatic t_multi();
      ctrl_s c;
      int ch, k1;
      do_reset();
      c = CTRL_RST;
      c.nch_m1 = 4'h3;
      wctrl(c);
      apb(1'b1, ADR_CHSEL, 32'h1);
      apb(1'b1, ADR_INC_HI, 32'h0000_4000);
      step(4);
      ch = last.chan;
      k1 = -1;
      for (int i = 0; i < 16; i++) begin
         step(1);
         chk("chan order", 32'(last.chan), 32'((ch + 1) % 4));
         ch = last.chan;
         if (ch == 0) chk("chan0 still", {last.cos, last.sin}, exp_smp(0, c, AMP_FULL));
         if (ch == 1 && k1 >= 0) chk("chan1 step", {last.cos, last.sin}, exp_smp(k1 + 1, c, AMP_FULL));
         if (ch == 1) k1 = findk({last.cos, last.sin}, AMP_FULL);
      end
      c.nch_m1 = 4'hf;
      wctrl(c);
      step(4);
      ch = last.chan;
      for (int i = 0; i < 20; i++) begin
         step(1);
         chk("chan order 16", 32'(last.chan), 32'((ch + 1) % 16));
         ch = last.chan;
      end
      chk("stream valid", 32'(last.valid && cnt != 16'h0), 32'h1);
   endtask
   // ----------------------------------------------------------------
   // sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      do_reset();
      t_regs();
      t_rot();
      t_offs();
      t_multi();
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      test_done();
   end
endmodule // phase_accumulator_sine_synth_bench
